// >>> verilog/lde_pkg.sv
// Constants shared by the open-LED and thermal error readout block
package lde_pkg;
    // Channel count and settling counter width
    localparam int CH_N           = 16;
    localparam int CNT_W          = 8;

    // Clock period of the sampling clock
    localparam int CLK_PERIOD_NS  = 10;

    // Open-LED settling: delay after sink turn-on, blank-to-output, stagger
    localparam int SETTLE_NS      = 1000;
    localparam int TPD_BLANK_NS   = 60;
    localparam int STAGGER_NS     = 30;

    // Least times round up to whole cycles
    localparam int VALID_BASE_CYC =
        (TPD_BLANK_NS + SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VALID_STEP_CYC =
        (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Nominal over-temperature trip point in degrees C, sensed off-chip
    localparam int OVERTEMP_THRESH_C = 160;

    // APB register byte offsets
    localparam logic [11:0] ONOFF_OFS   = 12'h0000;
    localparam logic [11:0] STATUS_OFS  = 12'h0004;
    localparam logic [11:0] CAPTURE_OFS = 12'h0008;

    // Status register field positions
    localparam int ST_THERMAL_POS = 0;
    localparam int ST_ERRDRV_POS  = 1;
    localparam int ST_ERRPIN_POS  = 2;
    localparam int ST_BLANK_POS   = 3;
    localparam int ST_MODE_POS    = 4;
    localparam int ST_LIVE_POS    = 16;

    // Capture register field positions
    localparam int CAP_LATCH_POS  = 0;
    localparam int CAP_SHIFT_POS  = 16;

    // Reset values
    localparam logic [15:0] ONOFF_RST   = 16'h0000;
    localparam logic [15:0] STATUS_RST  = 16'h0000;
    localparam logic [15:0] SHREG_RST   = 16'h0000;
    localparam logic [31:0] PRDATA_RST  = 32'h0000_0000;
endpackage : lde_pkg

// >>> verilog/lde_sync.sv
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
`default_nettype none
module lde_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] val;
    } lde_sync_t;

    lde_sync_t s_q;
    lde_sync_t s_d;

    // Value moves only once stages two and three agree, filtering one-cycle glitches
    always_comb
    begin
        s_d     = s_q;
        s_d.ff1 = async_in;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        s_d.val = (s_q.ff2 & s_q.ff3) | (s_q.val & (s_q.ff2 | s_q.ff3));
    end

    // Synchronous reset to zero
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.val;
endmodule : lde_sync
`default_nettype wire

// >>> verilog/lde_err_readout.sv
// Open-LED and thermal error detection, status latch and serial readout
//
// Contract
// - Over-temperature sets the thermal flag and pulls error output low.
// - Cooling clears the thermal flag; output released unless an open LED.
// - Open LED only with blanking low, channel on, output voltage low.
// - Any open channel pulls the open-drain error output to ground.
// - Status bit is one only for a faulty LED on a switched-on channel.
// - Channel 0 status valid 60 ns plus 1 us after blanking falls.
// - Each further channel becomes valid 30 ns after the previous one.
// - Mode low: strobe rising edge captures all open flags into latch.
// - Latch holds its capture regardless of later live flag changes.
// - Mode low, strobe high: latch forces shift register bits, serial input ignored.
// - Forcing beats shifting; in mode low, shift clocks under strobe change nothing.
// - Mode low, strobe high: serial output shows channel 15 status.
// - Strobe falling: shift register keeps loaded bits, latch disconnects.
// - Strobe low: each shift clock rising edge moves output to next lower channel.
// - Readout with strobe low works with blanking high or low.
// - Mode low: input shift register is sixteen bits, one per channel.
// - Blanking high masks open-LED detection from the error output.
// - Shift clock edge moves serial input in; most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module lde_err_readout #(
    parameter int CH_N = lde_pkg::CH_N
) (
    // Clock and reset
    input  wire logic            MCLK_IN,
    input  wire logic            RST_N_IN,
    // APB slave
    input  wire logic            PSEL_IN,
    input  wire logic            PENABLE_IN,
    input  wire logic            PWRITE_IN,
    input  wire logic [11:0]     PADDR_IN,
    input  wire logic [31:0]     PWDATA_IN,
    input  wire logic [3:0]      PSTRB_IN,
    output logic      [31:0]     PRDATA_OUT,
    output logic                 PREADY_OUT,
    output logic                 PSLVERR_OUT,
    // Serial readout pins
    input  wire logic            SHIFT_CLK_IN,
    input  wire logic            LATCH_STROBE_IN,
    input  wire logic            SERIAL_IN_IN,
    output logic                 SERIAL_OUT_OUT,
    // Channel control and sense inputs
    input  wire logic            BLANK_IN,
    input  wire logic            MODE_IN,
    input  wire logic            OVERTEMP_IN,
    input  wire logic [CH_N-1:0] OUT_LOW_IN,
    // Open-drain error pin
    input  wire logic            ERROR_OUT_N_IN,
    output logic                 ERROR_OUT_N_OUT,
    output logic                 ERROR_OUT_N_OE_OUT
);
    localparam int SYNC_W = CH_N + 7;
    localparam int CNT_W  = lde_pkg::CNT_W;

    // All registered state of the block apart from the pin synchroniser
    typedef struct packed {
        logic [CH_N-1:0]  onoff;
        logic [CH_N-1:0]  status;
        logic [CH_N-1:0]  shreg;
        logic [CNT_W-1:0] settle_cnt;
        logic             sclk_prev;
        logic             strobe_prev;
        logic             err_oe;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } lde_state_t;

    lde_state_t        st_q;
    lde_state_t        st_d;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic              sclk_s;
    logic              strobe_s;
    logic              sin_s;
    logic              blank_s;
    logic              mode_s;
    logic              overtemp_s;
    logic              errpin_s;
    logic [CH_N-1:0]   out_low_s;
    logic [CH_N-1:0]   ch_valid;
    logic [CH_N-1:0]   open_live;
    logic              thermal_flag;
    logic              sclk_rise;
    logic              strobe_rise;
    logic              any_open;
    logic              apb_setup;
    logic              apb_access;
    logic              apb_wr;
    logic [31:0]       rd_mux;
    logic              rd_err;

    // Every serial, sense and error pin is asynchronous to MCLK, including the shift clock itself
    assign pins_async = {ERROR_OUT_N_IN, OVERTEMP_IN, MODE_IN, BLANK_IN,
                         SERIAL_IN_IN, LATCH_STROBE_IN, SHIFT_CLK_IN, OUT_LOW_IN};

    lde_sync #(
        .W        (SYNC_W)
    ) u_sync (
        .clk_in   (MCLK_IN),
        .rst_n_in (RST_N_IN),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // Unpack synchronised pins; data and clock share latency so setup holds
    assign out_low_s  = pins_sync[CH_N-1:0];
    assign sclk_s     = pins_sync[CH_N];
    assign strobe_s   = pins_sync[CH_N+1];
    assign sin_s      = pins_sync[CH_N+2];
    assign blank_s    = pins_sync[CH_N+3];
    assign mode_s     = pins_sync[CH_N+4];
    assign overtemp_s = pins_sync[CH_N+5];
    assign errpin_s   = pins_sync[CH_N+6];

    // Edge detection on the settled pin levels
    assign sclk_rise   = sclk_s & ~st_q.sclk_prev;
    assign strobe_rise = strobe_s & ~st_q.strobe_prev;

    // Comparator asserts above the trip point; flag follows it both ways
    assign thermal_flag = overtemp_s;

    // Per-channel settling windows, staggered from the blanking release
    genvar g;
    generate
        for (g = 0; g < CH_N; g = g + 1)
        begin : g_ch
            localparam logic [CNT_W-1:0] VALID_AT =
                CNT_W'(lde_pkg::VALID_BASE_CYC + g * lde_pkg::VALID_STEP_CYC);
            assign ch_valid[g] = (st_q.settle_cnt >= VALID_AT);
            assign open_live[g] = ~blank_s & st_q.onoff[g] & out_low_s[g]
                                & ch_valid[g];
        end
    endgenerate

    assign any_open = |open_live;

    // APB phase decode
    assign apb_setup  = PSEL_IN & ~PENABLE_IN;
    assign apb_access = PSEL_IN & PENABLE_IN & st_q.pready;
    assign apb_wr     = apb_access & PWRITE_IN;

    // Read data selection; unmapped offsets answer zero with an error
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (PADDR_IN)
            lde_pkg::ONOFF_OFS:
            begin
                rd_mux[CH_N-1:0] = st_q.onoff;
            end
            lde_pkg::STATUS_OFS:
            begin
                rd_mux[lde_pkg::ST_THERMAL_POS] = thermal_flag;
                rd_mux[lde_pkg::ST_ERRDRV_POS]  = st_q.err_oe;
                rd_mux[lde_pkg::ST_ERRPIN_POS]  = errpin_s;
                rd_mux[lde_pkg::ST_BLANK_POS]   = blank_s;
                rd_mux[lde_pkg::ST_MODE_POS]    = mode_s;
                rd_mux[lde_pkg::ST_LIVE_POS +: CH_N] = open_live;
            end
            lde_pkg::CAPTURE_OFS:
            begin
                rd_mux[lde_pkg::CAP_LATCH_POS +: CH_N] = st_q.status;
                rd_mux[lde_pkg::CAP_SHIFT_POS +: CH_N] = st_q.shreg;
            end
            default:
            begin
                rd_err = 1'b1;
            end
        endcase
    end

    // Next-state logic for the whole block
    always_comb
    begin
        st_d = st_q;

        // Edge history
        st_d.sclk_prev   = sclk_s;
        st_d.strobe_prev = strobe_s;

        // Settling counter runs while blanking is low and saturates
        if (blank_s)
        begin
            st_d.settle_cnt = '0;
        end
        else if (st_q.settle_cnt != {CNT_W{1'b1}})
        begin
            st_d.settle_cnt = st_q.settle_cnt + CNT_W'(1);
        end

        // Error pin drive: thermal always, open LEDs only when unblanked
        st_d.err_oe = thermal_flag | any_open;

        // Status latch and shift register; forcing has priority over shifting
        if (!mode_s && strobe_s)
        begin
            if (strobe_rise)
            begin
                st_d.status = open_live;
                st_d.shreg  = open_live;
            end
            else
            begin
                st_d.shreg  = st_q.status;
            end
        end
        else if (sclk_rise)
        begin
            // Status leaves the top while new bits enter the bottom
            st_d.shreg = {st_q.shreg[CH_N-2:0], sin_s};
        end

        // No wait states: ready is raised in the cycle after setup
        st_d.pready  = apb_setup;
        st_d.pslverr = apb_setup & rd_err;
        if (apb_setup && !PWRITE_IN)
        begin
            st_d.prdata = rd_mux;
        end
        else if (apb_setup)
        begin
            st_d.prdata = lde_pkg::PRDATA_RST;
        end

        // Byte-lane writes to the on/off mask; other offsets are read only
        if (apb_wr && (PADDR_IN == lde_pkg::ONOFF_OFS))
        begin
            if (PSTRB_IN[0])
            begin
                st_d.onoff[7:0] = PWDATA_IN[7:0];
            end
            if (PSTRB_IN[1])
            begin
                st_d.onoff[15:8] = PWDATA_IN[15:8];
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            st_q.onoff       <= lde_pkg::ONOFF_RST;
            st_q.status      <= lde_pkg::STATUS_RST;
            st_q.shreg       <= lde_pkg::SHREG_RST;
            st_q.settle_cnt  <= '0;
            st_q.sclk_prev   <= 1'b0;
            st_q.strobe_prev <= 1'b0;
            st_q.err_oe      <= 1'b0;
            st_q.prdata      <= lde_pkg::PRDATA_RST;
            st_q.pready      <= 1'b0;
            st_q.pslverr     <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Output drive; open-drain data is constant low, only the enable moves
    assign PRDATA_OUT         = st_q.prdata;
    assign PREADY_OUT         = st_q.pready;
    assign PSLVERR_OUT        = st_q.pslverr;
    assign SERIAL_OUT_OUT     = st_q.shreg[CH_N-1];
    assign ERROR_OUT_N_OUT    = 1'b0;
    assign ERROR_OUT_N_OE_OUT = st_q.err_oe;
endmodule : lde_err_readout
`default_nettype wire

// >>> verif/lde_err_readout_sva.sv
// Assertion checker for the error readout block
`timescale 1ns/1ps
`default_nettype none
module lde_err_readout_chk #(
    parameter int CH_N = lde_pkg::CH_N
) (
    input wire logic            MCLK_IN,
    input wire logic            RST_N_IN,
    input wire logic            PSEL_IN,
    input wire logic            PENABLE_IN,
    input wire logic            PREADY_OUT,
    input wire logic            PSLVERR_OUT,
    input wire logic            SHIFT_CLK_IN,
    input wire logic            LATCH_STROBE_IN,
    input wire logic            SERIAL_OUT_OUT,
    input wire logic            BLANK_IN,
    input wire logic            MODE_IN,
    input wire logic            OVERTEMP_IN,
    input wire logic [CH_N-1:0] OUT_LOW_IN,
    input wire logic            ERROR_OUT_N_OUT,
    input wire logic            ERROR_OUT_N_OE_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Eight cycles cover the pin synchronisers plus the output flop
    sequence s_setup;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence s_strobe_held;
        (LATCH_STROBE_IN && !MODE_IN)[*8];
    endsequence
    property p_ready;
        s_setup |=> PREADY_OUT ##1 !PREADY_OUT;
    endproperty
    property p_slverr;
        PSLVERR_OUT |-> PREADY_OUT;
    endproperty
    property p_hot;
        OVERTEMP_IN[*8] |=> ERROR_OUT_N_OE_OUT;
    endproperty
    property p_cool;
        (!OVERTEMP_IN && OUT_LOW_IN == '0)[*8] |=> !ERROR_OUT_N_OE_OUT;
    endproperty
    property p_mask;
        (!OVERTEMP_IN && BLANK_IN)[*8] |=> !ERROR_OUT_N_OE_OUT;
    endproperty
    property p_pull;
        ERROR_OUT_N_OE_OUT |-> ERROR_OUT_N_OUT == 1'b0;
    endproperty
    property p_force;
        s_strobe_held |=> $stable(SERIAL_OUT_OUT);
    endproperty
    property p_idle;
        (!LATCH_STROBE_IN && !SHIFT_CLK_IN)[*8] |=> $stable(SERIAL_OUT_OUT);
    endproperty
    a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
    a_slverr: assert property (p_slverr) else $error("error flag without ready");
    a_hot: assert property (p_hot) else $error("hot die not flagged");
    a_cool: assert property (p_cool) else $error("error pin not released");
    a_mask: assert property (p_mask) else $error("blanking did not mask");
    a_pull: assert property (p_pull) else $error("error pin not pulled low");
    a_force: assert property (p_force) else $error("output moved under strobe");
    a_idle: assert property (p_idle) else $error("output moved without edge");
endmodule : lde_err_readout_chk
bind lde_err_readout lde_err_readout_chk #(.CH_N(CH_N)) i_chk (.MCLK_IN(MCLK_IN),
    .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .SHIFT_CLK_IN(SHIFT_CLK_IN),
    .LATCH_STROBE_IN(LATCH_STROBE_IN), .SERIAL_OUT_OUT(SERIAL_OUT_OUT),
    .BLANK_IN(BLANK_IN), .MODE_IN(MODE_IN), .OVERTEMP_IN(OVERTEMP_IN),
    .OUT_LOW_IN(OUT_LOW_IN), .ERROR_OUT_N_OUT(ERROR_OUT_N_OUT),
    .ERROR_OUT_N_OE_OUT(ERROR_OUT_N_OE_OUT));
`default_nettype wire

// >>> verif/lde_ctl_model.sv
// Controller model driving the serial readout pins
`timescale 1ns/1ps
`default_nettype none
module lde_ctl_model (
    input  wire logic serial_out_in,
    output logic      shift_clk_out,
    output logic      latch_strobe_out,
    output logic      serial_in_out
);
    // Idle levels; the shift clock stands low between frames
    initial
    begin
        shift_clk_out = 1'b0;
        latch_strobe_out = 1'b0;
        serial_in_out = 1'b0;
    end
    // One 125 ns shift clock period, unrelated to the system clock
    task automatic pulse();
        #62.5 shift_clk_out = 1'b1;
        #62.5 shift_clk_out = 1'b0;
    endtask : pulse
    // Optional capture, then sixteen bits out, top channel first
    task automatic frame(input bit cap, input logic [15:0] serial_in, output logic hi,
                         output logic [15:0] got);
        if (cap)
        begin
            latch_strobe_out = 1'b1;
            pulse();
            hi = serial_out_in;
            latch_strobe_out = 1'b0;
        end
        #100;
        // Strobe stays low until every bit is out
        for (int i = 15; i >= 0; i--)
        begin
            got[i] = serial_out_in;
            serial_in_out = serial_in[i];
            pulse();
        end
        // Chain released: never leave the last level standing
        serial_in_out = ~serial_in_out;
    endtask : frame
endmodule : lde_ctl_model
`default_nettype wire

// >>> verif/tb_lde_err_readout.sv
// Self-checking bench for the error readout block
`timescale 1ns/1ps
`default_nettype none
module tb_lde_err_readout;
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        blank = 1'b1, overtemp = 1'b0, mode = 1'b0, e, hi;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [15:0] out_low = 16'h0000, got, shin;
    logic        pready, pslverr, sclk, strobe, serial_in, serial_out, err_od, err_oe, err_net;
    int          num_errors = 0, cmp_count = 0, onoff, low, exp;
    always #5 mclk = ~mclk;
    // Wired error net with its pull-up
    assign err_net = err_oe ? err_od : 1'b1;
    lde_err_readout i_dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PSTRB_IN(4'hf), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .SHIFT_CLK_IN(sclk), .LATCH_STROBE_IN(strobe), .SERIAL_IN_IN(serial_in),
        .SERIAL_OUT_OUT(serial_out), .BLANK_IN(blank), .MODE_IN(mode), .OVERTEMP_IN(overtemp),
        .OUT_LOW_IN(out_low), .ERROR_OUT_N_IN(err_net), .ERROR_OUT_N_OUT(err_od),
        .ERROR_OUT_N_OE_OUT(err_oe));
    lde_ctl_model i_ctl (.serial_out_in(serial_out), .shift_clk_out(sclk),
        .latch_strobe_out(strobe), .serial_in_out(serial_in));
    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, s, x);
        end
    endtask : chk
    // One APB transfer; waits for ready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            end_sim();
        end
    endtask : apb
    // Main sequence: settling, random captures, thermal, unmapped read
    initial
    begin
        void'($urandom(35));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b1, lde_pkg::ONOFF_OFS, 32'h0000_8001);
        for (int ch = 0; ch < 16; ch += 15)
        begin
            out_low <= 16'h0001 << ch;
            blank <= 1'b1;
            repeat (10) @(posedge mclk);
            blank <= 1'b0;
            repeat (105 + 3 * ch) @(posedge mclk);
            chk(err_oe, 1'b0);
            repeat (14) @(posedge mclk);
            chk(err_oe, 1'b1);
        end
        repeat (2)
        begin
            onoff = $urandom & 32'h0000_ffff;
            low = $urandom & 32'h0000_ffff;
            exp = onoff & low;
            shin = 16'($urandom);
            apb(1'b1, lde_pkg::ONOFF_OFS, onoff);
            apb(1'b0, lde_pkg::ONOFF_OFS, 32'h0000_0000);
            chk(q, onoff);
            out_low <= low[15:0];
            blank <= 1'b1;
            repeat (10) @(posedge mclk);
            blank <= 1'b0;
            repeat (170) @(posedge mclk);
            chk(err_oe, exp != 0);
            apb(1'b0, lde_pkg::STATUS_OFS, 32'h0000_0000);
            chk(q[31:16], exp);
            i_ctl.frame(1'b1, shin, hi, got);
            @(posedge mclk);
            chk(hi, exp[15]);
            chk(got, exp);
            out_low <= ~low[15:0];
            blank <= 1'b1;
            repeat (20) @(posedge mclk);
            apb(1'b0, lde_pkg::CAPTURE_OFS, 32'h0000_0000);
            chk(q[15:0], exp[15:0]);
            chk(q[31:16], shin);
            chk(err_oe, 1'b0);
            i_ctl.frame(1'b0, 16'h0000, hi, got);
            @(posedge mclk);
            chk(got, shin);
        end
        // Mode high: a strobe with live opens present must leave the latch alone
        mode <= 1'b1;
        blank <= 1'b0;
        repeat (170) @(posedge mclk);
        i_ctl.frame(1'b1, 16'h0000, hi, got);
        @(posedge mclk);
        apb(1'b0, lde_pkg::CAPTURE_OFS, 32'h0000_0000);
        chk(q[15:0], exp[15:0]);
        mode <= 1'b0;
        blank <= 1'b1;
        overtemp <= 1'b1;
        repeat (10) @(posedge mclk);
        chk(err_oe, 1'b1);
        apb(1'b0, lde_pkg::STATUS_OFS, 32'h0000_0000);
        chk(q[0], 1'b1);
        overtemp <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(err_oe, 1'b0);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        chk(e, 1'b1);
        end_sim();
    end
endmodule : tb_lde_err_readout
`default_nettype wire
